/* stg_defs.vh */
// Constants for the solenoid trigger gate: register map, field positions,
// reset values and timing figures. Assumes a 25 MHz system clock.
`ifndef STG_DEFS_VH
`define STG_DEFS_VH

// Register offsets on the 4-bit register port
`define STG_ADDR_CTRL 4'h0
`define STG_ADDR_CMD 4'h1
`define STG_ADDR_STATUS 4'h2

// Control register fields
`define STG_CTRL_MODE_LO 0
`define STG_CTRL_MODE_HI 1
`define STG_CTRL_POL 2
`define STG_CTRL_A_OUT 3
`define STG_CTRL_B_OUT 4
`define STG_CTRL_RESET 16'h0014

// Operating modes
`define STG_MODE_MANUAL 2'h0
`define STG_MODE_SINGLE 2'h1
`define STG_MODE_AUTO 2'h2
`define STG_MODE_TRIG 2'h3

// Command register bits, each a one-shot on write
`define STG_CMD_ON 0
`define STG_CMD_OFF 1
`define STG_CMD_IDENT 2

// Status register fields
`define STG_ST_SOL 0
`define STG_ST_PRIMED 1
`define STG_ST_ILK 2
`define STG_ST_TRIG 3
`define STG_ST_FLASH 4
`define STG_ST_PWR_LO 5
`define STG_ST_PWR_HI 8

// Timing: clock in kHz, times in ms (25000 kHz, 5000 ms, 3000 ms, 125 ms)
`define STG_CLK_KHZ 32'h0000_61a8
`define STG_WARM_MS 32'h0000_1388
`define STG_CANCEL_MS 32'h0000_0bb8
`define STG_FLASH_HALF_MS 32'h0000_007d
`define STG_FLASH_HALVES 4'h8

`endif

/* stg_sync.v */
// Two-stage synchroniser for the asynchronous trigger and interlock lines.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ns
module stg_sync (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] d_i,
  output wire [2:0] q_o
);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d_i[gi];
          sync_r <= meta_r;
        end
      end
      assign q_o[gi] = sync_r;
    end
  endgenerate
endmodule

/* stg_gate.v */
// Solenoid trigger gate: decides when the solenoid drive is on, runs the
// power sequence and the identify flash, and holds the register port.
// Assumes a 25 MHz clock, a synchronous reset at power-on, wheel pulses
// synchronous to the clock, and a non-volatile store answering save_done_i.
//
// Notes on behaviour
// - Trigger input acts only in triggered mode
// - After reset port a input, b output
// - Selectable trigger polarity, high or low
// - Triggered: solenoid follows active trigger level
// - Trigger ignored until primed by wheel/host
// - Open trigger input reads as low
// - Active low, open input: on once primed
// - Active high, open input: stays off
// - Trigger alone never turns solenoid on
// - Open interlock loop blocks solenoid enable
// - Standby switch: save parameters, then power off
// - Early switch-on aborts power-off, save completes
// - About five seconds warm-up after power
// - Identify command flashes the display
// - Manual mode: host on/off drives solenoid
// - Wheel down always turns solenoid off
// - Manual: wheel up on, down off
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "stg_defs.vh"
module stg_gate #(
  parameter [31:0] WARM_CYC = `STG_WARM_MS * `STG_CLK_KHZ,
  parameter [31:0] CANCEL_CYC = `STG_CANCEL_MS * `STG_CLK_KHZ,
  parameter [31:0] FLASH_HALF_CYC = `STG_FLASH_HALF_MS * `STG_CLK_KHZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [15:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output wire [15:0] rd_data_o,
  input wire wheel_up_i,
  input wire wheel_down_i,
  input wire power_sw_i,
  input wire save_done_i,
  input wire interlock_closed_i,
  input wire trigger_port_a_i,
  output wire trigger_port_a_o,
  output wire trigger_port_a_oe_o,
  input wire trigger_port_b_i,
  output wire trigger_port_b_o,
  output wire trigger_port_b_oe_o,
  output wire solenoid_drive_o,
  output wire power_hold_o,
  output wire save_start_o,
  output wire display_flash_o
);
  localparam [3:0] ST_WARM = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_SAVE = 4'h4;
  localparam [3:0] ST_OFF = 4'h8;

  function is_mode;
    input [1:0] mode;
    input [1:0] want;
    begin
      is_mode = (mode == want);
    end
  endfunction

  reg [15:0] ctrl_r;
  reg [15:0] rd_data_r;
  reg sol_r;
  reg sol_nxt;
  reg primed_r;
  reg primed_nxt;
  reg [3:0] pwr_r;
  reg [3:0] pwr_nxt;
  reg [31:0] pwr_cnt_r;
  reg [31:0] pwr_cnt_nxt;
  reg abort_r;
  reg abort_nxt;
  reg saved_r;
  reg saved_nxt;
  reg save_start_r;
  reg save_start_nxt;
  reg flash_r;
  reg [3:0] flash_left_r;
  reg [31:0] flash_tmr_r;
  reg trig_out_a_r;
  reg trig_out_b_r;

  wire [2:0] sync_q;
  wire trig_a_s;
  wire trig_b_s;
  wire ilk_ok;
  wire [1:0] mode;
  wire pol_high;
  wire a_out;
  wire b_out;
  wire trig_level;
  wire trig_active;
  wire run;
  wire cmd_wr;
  wire host_on;
  wire host_off;
  wire host_ident;
  wire trig_mode;
  wire [15:0] status;

  stg_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({interlock_closed_i, trigger_port_b_i, trigger_port_a_i}),
    .q_o(sync_q)
  );
  assign trig_a_s = sync_q[0];
  assign trig_b_s = sync_q[1];
  assign ilk_ok = sync_q[2];

  assign mode = ctrl_r[`STG_CTRL_MODE_HI:`STG_CTRL_MODE_LO];
  assign pol_high = ctrl_r[`STG_CTRL_POL];
  assign a_out = ctrl_r[`STG_CTRL_A_OUT];
  assign b_out = ctrl_r[`STG_CTRL_B_OUT];
  assign trig_mode = is_mode(mode, `STG_MODE_TRIG);
  assign run = (pwr_r == ST_RUN);

  assign cmd_wr = wr_i && (addr_i == `STG_ADDR_CMD);
  assign host_on = cmd_wr && wr_data_i[`STG_CMD_ON];
  assign host_off = cmd_wr && wr_data_i[`STG_CMD_OFF];
  assign host_ident = cmd_wr && wr_data_i[`STG_CMD_IDENT];

  // open input low
  // The first port set as input is the trigger; with none, the level is low
  assign trig_level = !a_out ? trig_a_s : (!b_out ? trig_b_s : 1'b0);

  assign trig_active = pol_high ? trig_level : !trig_level;

  // Control register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `STG_CTRL_RESET;
    end else if (wr_i && (addr_i == `STG_ADDR_CTRL)) begin
      ctrl_r <= {11'h000, wr_data_i[4:0]};
    end
  end

  // Priming and solenoid decision
  always @* begin
    primed_nxt = primed_r;
    sol_nxt = sol_r;
    if (trig_mode) begin
      // priming needed
      // Set wins over a simultaneous ordinary clear
      if (wheel_up_i || host_on) begin
        primed_nxt = 1'b1;
      end else if (wheel_down_i || host_off) begin
        primed_nxt = 1'b0;
      end
      sol_nxt = primed_nxt && trig_active;
    end else begin
      primed_nxt = 1'b0;
      if (wheel_up_i) begin
        sol_nxt = 1'b1;
      end else if (wheel_down_i) begin
        sol_nxt = 1'b0;
      end
      if (is_mode(mode, `STG_MODE_MANUAL)) begin
        if (host_on) begin
          sol_nxt = 1'b1;
        end else if (host_off) begin
          sol_nxt = 1'b0;
        end
      end
    end
    if (wheel_down_i) begin
      sol_nxt = 1'b0;
    end
    // interlock drops state
    // Safety clears win over every set
    if (!ilk_ok || !run) begin
      sol_nxt = 1'b0;
      primed_nxt = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sol_r <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      sol_r <= sol_nxt;
      primed_r <= primed_nxt;
    end
  end

  // Trigger ports that are outputs repeat the solenoid state in the
  // selected active polarity, so cubes can be chained.
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_out_a_r <= 1'b0;
      trig_out_b_r <= 1'b0;
    end else begin
      trig_out_a_r <= pol_high ? sol_nxt : !sol_nxt;
      trig_out_b_r <= pol_high ? sol_nxt : !sol_nxt;
    end
  end

  // Power sequence
  always @* begin
    pwr_nxt = pwr_r;
    pwr_cnt_nxt = pwr_cnt_r;
    abort_nxt = abort_r;
    saved_nxt = saved_r;
    save_start_nxt = 1'b0;
    case (pwr_r)
      ST_WARM: begin
        if (pwr_cnt_r >= WARM_CYC - 32'h1) begin
          pwr_nxt = ST_RUN;
          pwr_cnt_nxt = 32'h0;
        end else begin
          pwr_cnt_nxt = pwr_cnt_r + 32'h1;
        end
      end
      ST_RUN: begin
        if (!power_sw_i) begin
          pwr_nxt = ST_SAVE;
          pwr_cnt_nxt = 32'h0;
          abort_nxt = 1'b0;
          saved_nxt = 1'b0;
          save_start_nxt = 1'b1;
        end
      end
      ST_SAVE: begin
        if (pwr_cnt_r < CANCEL_CYC - 32'h1) begin
          pwr_cnt_nxt = pwr_cnt_r + 32'h1;
          if (power_sw_i) begin
            abort_nxt = 1'b1;
          end
        end
        if (save_done_i) begin
          saved_nxt = 1'b1;
        end
        if (saved_nxt && abort_nxt) begin
          pwr_nxt = ST_RUN;
          pwr_cnt_nxt = 32'h0;
        end else if (saved_nxt && (pwr_cnt_nxt >= CANCEL_CYC - 32'h1)) begin
          pwr_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        pwr_nxt = ST_OFF;
      end
      default: begin
        pwr_nxt = ST_WARM;
        pwr_cnt_nxt = 32'h0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_r <= ST_WARM;
      pwr_cnt_r <= 32'h0;
      abort_r <= 1'b0;
      saved_r <= 1'b0;
      save_start_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
      abort_r <= abort_nxt;
      saved_r <= saved_nxt;
      save_start_r <= save_start_nxt;
    end
  end

  // Identify flash: a fixed number of half periods, restarted by a new request
  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_r <= 1'b0;
      flash_left_r <= 4'h0;
      flash_tmr_r <= 32'h0;
    end else if (host_ident) begin
      flash_r <= 1'b1;
      flash_left_r <= `STG_FLASH_HALVES;
      flash_tmr_r <= 32'h0;
    end else if (flash_left_r != 4'h0) begin
      if (flash_tmr_r >= FLASH_HALF_CYC - 32'h1) begin
        flash_tmr_r <= 32'h0;
        flash_left_r <= flash_left_r - 4'h1;
        flash_r <= (flash_left_r == 4'h1) ? 1'b0 : !flash_r;
      end else begin
        flash_tmr_r <= flash_tmr_r + 32'h1;
      end
    end
  end

  // Read port: data stand only in the cycle after the read strobe
  assign status = {7'h00, pwr_r, flash_r, trig_active, ilk_ok, primed_r, sol_r};

  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `STG_ADDR_CTRL: rd_data_r <= ctrl_r;
        `STG_ADDR_STATUS: rd_data_r <= status;
        default: rd_data_r <= 16'h0000;
      endcase
    end else begin
      rd_data_r <= 16'h0000;
    end
  end

  assign rd_data_o = rd_data_r;
  assign solenoid_drive_o = sol_r;
  assign power_hold_o = (pwr_r != ST_OFF);
  assign save_start_o = save_start_r;
  assign display_flash_o = flash_r;
  assign trigger_port_a_o = trig_out_a_r;
  assign trigger_port_a_oe_o = a_out;
  assign trigger_port_b_o = trig_out_b_r;
  assign trigger_port_b_oe_o = b_out;
endmodule

/* stg_sva.sv */
// Checker for the solenoid trigger gate, bound to every stg_gate.
// Sees only the top ports; follows mode and polarity from bus writes.
`timescale 1ns/1ns
`include "stg_defs.vh"
module stg_sva #(
  parameter [31:0] WARM_CYC = 32'h14
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [15:0] wr_data_i,
  input wire wr_i,
  input wire wheel_down_i,
  input wire power_sw_i,
  input wire interlock_closed_i,
  input wire trigger_port_a_i,
  input wire trigger_port_a_oe_o,
  input wire trigger_port_b_oe_o,
  input wire trigger_port_a_o,
  input wire trigger_port_b_o,
  input wire solenoid_drive_o,
  input wire power_hold_o,
  input wire save_start_o,
  input wire display_flash_o
);
  reg [1:0] mode_r;
  reg pol_r;
  reg [31:0] cnt_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= `STG_MODE_MANUAL;
      pol_r <= 1'b1;
      cnt_r <= 32'h0;
    end else begin
      if (cnt_r < WARM_CYC)
        cnt_r <= cnt_r + 32'h1;
      if (wr_i && addr_i == `STG_ADDR_CTRL) begin
        mode_r <= wr_data_i[1:0];
        pol_r <= wr_data_i[`STG_CTRL_POL];
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ident;
    wr_i && addr_i == `STG_ADDR_CMD && wr_data_i[`STG_CMD_IDENT];
  endsequence
  sequence s_ilk_open;
    !interlock_closed_i [*3];
  endsequence
  sequence s_open_hi;
    (mode_r == `STG_MODE_TRIG && pol_r && !trigger_port_a_oe_o && !trigger_port_a_i) [*3];
  endsequence
  AST_PORT_DIR: assert property ($fell(rst_i) |-> !trigger_port_a_oe_o && trigger_port_b_oe_o)
    else $error("port directions wrong after reset");
  AST_ILK_OFF: assert property (s_ilk_open |=> !solenoid_drive_o)
    else $error("solenoid on with interlock open");
  AST_WHEEL_DN: assert property (wheel_down_i |=> !solenoid_drive_o)
    else $error("solenoid on after wheel down");
  AST_OPEN_HI: assert property (s_open_hi |=> !solenoid_drive_o)
    else $error("open input acted as active high trigger");
  AST_HOST_OFF: assert property (wr_i && addr_i == `STG_ADDR_CMD && wr_data_i[1:0] == 2'h2
    && mode_r == `STG_MODE_MANUAL |=> !solenoid_drive_o)
    else $error("host off ignored in manual mode");
  AST_WARM: assert property (solenoid_drive_o |-> cnt_r >= WARM_CYC)
    else $error("solenoid on during warm-up");
  // The solenoid may still be on in the pulse cycle; it drops one cycle later
  AST_SAVE_CAUSE: assert property (save_start_o |-> !$past(power_sw_i)
    ##1 !solenoid_drive_o)
    else $error("save started without standby");
  // Outputs use the polarity that stood one cycle before a control write lands
  AST_TRIG_MIRROR: assert property (trigger_port_b_o == ($past(pol_r) ? solenoid_drive_o
    : !solenoid_drive_o) && trigger_port_a_o == trigger_port_b_o)
    else $error("trigger output does not mirror solenoid");
  AST_OFF_STAYS: assert property (!power_hold_o |=> !power_hold_o)
    else $error("power returned after shutdown");
  AST_FLASH: assert property (s_ident |=> display_flash_o)
    else $error("identify did not start flash");
endmodule
bind stg_gate stg_sva #(.WARM_CYC(WARM_CYC)) chk_i (.clk_i, .rst_i, .addr_i, .wr_data_i,
  .wr_i, .wheel_down_i, .power_sw_i, .interlock_closed_i, .trigger_port_a_i,
  .trigger_port_a_oe_o, .trigger_port_b_oe_o, .trigger_port_a_o, .trigger_port_b_o,
  .solenoid_drive_o, .power_hold_o,
  .save_start_o, .display_flash_o);

/* stg_ext.sv */
// Outside logic equipment: drives the trigger line and the interlock loop.
// Assumes the bench resolves the trigger pin, pulled low when released.
`timescale 1ns/1ns
module stg_ext (
  input wire clk_i,
  input wire [2:0] cmd_i,
  output reg trig_o,
  output reg trig_oe_o,
  output reg ilk_closed_o
);
  // Command is {loop closed, drive, level}; changes only after an edge
  always @(posedge clk_i) begin
    ilk_closed_o <= cmd_i[2];
    trig_oe_o <= cmd_i[1];
    trig_o <= cmd_i[0];
  end
endmodule

/* tb_top.sv */
// Self-checking bench for stg_gate with shortened timing parameters.
// Assumes pull-downs on both trigger pins when nobody drives them.
`timescale 1ns/1ns
`include "stg_defs.vh"
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wr_data_i = 16'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg wheel_up_i = 1'b0;
  reg wheel_down_i = 1'b0;
  reg power_sw_i = 1'b1;
  reg save_done_i = 1'b0;
  reg [2:0] ext_cmd = 3'h4;
  wire [15:0] rd_data_o;
  wire trigger_port_a_o, trigger_port_a_oe_o, trigger_port_b_o, trigger_port_b_oe_o;
  wire outside_trigger_line, ext_oe, ilk, solenoid_drive_o, power_hold_o, save_start_o, display_flash_o;
  wire pin_a = trigger_port_a_oe_o ? trigger_port_a_o : (ext_oe ? outside_trigger_line : 1'b0);
  wire pin_b = trigger_port_b_oe_o ? trigger_port_b_o : 1'b0;
  integer n_errors = 0;
  integer samples_checked = 0;
  always #20 clk_i = ~clk_i;
  stg_ext ext (.clk_i(clk_i), .cmd_i(ext_cmd), .trig_o(outside_trigger_line), .trig_oe_o(ext_oe),
    .ilk_closed_o(ilk));
  stg_gate #(.WARM_CYC(32'h14), .CANCEL_CYC(32'ha), .FLASH_HALF_CYC(32'h4)) uut (.clk_i,
    .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .wheel_up_i, .wheel_down_i,
    .power_sw_i, .save_done_i, .interlock_closed_i(ilk), .trigger_port_a_i(pin_a),
    .trigger_port_a_o, .trigger_port_a_oe_o, .trigger_port_b_i(pin_b), .trigger_port_b_o,
    .trigger_port_b_oe_o, .solenoid_drive_o, .power_hold_o, .save_start_o, .display_flash_o);
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk("rd_data_o", exp, rd_data_o);
    end
  endtask
  task whl(input up);
    begin
      @(posedge clk_i);
      wheel_up_i <= up;
      wheel_down_i <= !up;
      @(posedge clk_i);
      wheel_up_i <= 1'b0;
      wheel_down_i <= 1'b0;
    end
  endtask
  // Pin changes need a partner edge plus three edges through the gate
  task sol_is(input e, input [3:0] n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
      chk("solenoid_drive_o", {15'h0, e}, {15'h0, solenoid_drive_o});
    end
  endtask
  task save_cycle(input back_on, input [4:0] tail);
    integer i;
    begin
      i = 0;
      @(posedge clk_i);
      power_sw_i <= 1'b0;
      #1;
      while (save_start_o !== 1'b1 && i < 40) begin
        @(posedge clk_i);
        #1;
        i = i + 1;
      end
      chk("save_start_o", 16'h1, {15'h0, save_start_o});
      @(posedge clk_i);
      power_sw_i <= back_on;
      @(posedge clk_i);
      save_done_i <= 1'b1;
      @(posedge clk_i);
      save_done_i <= 1'b0;
      repeat (tail) @(posedge clk_i);
    end
  endtask
  task results;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_errors = n_errors + 1;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("port_oe", 16'h1, {14'h0, trigger_port_a_oe_o, trigger_port_b_oe_o});
    rd(`STG_ADDR_CTRL, `STG_CTRL_RESET);
    rd(4'hf, 16'h0);
    whl(1'b1);
    sol_is(1'b0, 4'h0);
    repeat (25) @(posedge clk_i);
    rd(`STG_ADDR_STATUS, 16'h0044);
    whl(1'b1);
    sol_is(1'b1, 4'h0);
    whl(1'b0);
    sol_is(1'b0, 4'h0);
    wr(`STG_ADDR_CMD, 16'h1);
    sol_is(1'b1, 4'h0);
    wr(`STG_ADDR_CMD, 16'h2);
    sol_is(1'b0, 4'h0);
    // Low polarity with open input is active, but manual mode ignores it
    wr(`STG_ADDR_CTRL, 16'h0010);
    sol_is(1'b0, 4'h6);
    wr(`STG_ADDR_CTRL, 16'h0017);
    ext_cmd <= 3'h7;
    sol_is(1'b0, 4'h6);
    whl(1'b1);
    sol_is(1'b1, 4'h0);
    ext_cmd <= 3'h6;
    sol_is(1'b0, 4'h6);
    ext_cmd <= 3'h7;
    sol_is(1'b1, 4'h6);
    chk("trigger_port_b_o", 16'h1, {15'h0, trigger_port_b_o});
    ext_cmd <= 3'h4;
    sol_is(1'b0, 4'h6);
    wr(`STG_ADDR_CTRL, 16'h0013);
    whl(1'b0);
    sol_is(1'b0, 4'h0);
    wr(`STG_ADDR_CMD, 16'h1);
    sol_is(1'b1, 4'h0);
    chk("trigger_port_b_o", 16'h0, {15'h0, trigger_port_b_o});
    ext_cmd <= 3'h0;
    sol_is(1'b0, 4'h6);
    whl(1'b1);
    sol_is(1'b0, 4'h2);
    ext_cmd <= 3'h4;
    sol_is(1'b0, 4'h6);
    rd(`STG_ADDR_STATUS, 16'h004c);
    wr(`STG_ADDR_CMD, 16'h4);
    #1;
    chk("display_flash_o", 16'h1, {15'h0, display_flash_o});
    repeat (40) @(posedge clk_i);
    #1;
    chk("display_flash_o", 16'h0, {15'h0, display_flash_o});
    save_cycle(1'b1, 5'h2);
    rd(`STG_ADDR_STATUS, 16'h004c);
    save_cycle(1'b0, 5'hf);
    #1;
    chk("power_hold_o", 16'h0, {15'h0, power_hold_o});
    @(posedge clk_i);
    power_sw_i <= 1'b1;
    sol_is(1'b0, 4'h4);
    chk("power_hold_o", 16'h0, {15'h0, power_hold_o});
    results;
  end
endmodule
